// File: hdl/tm_pkg.sv
package tm_pkg;
  // bus identity
  localparam logic [6:0] ADDR_DEFAULT = 7'h4c;  // default variant
  localparam logic [6:0] ADDR_ALT     = 7'h4d;  // alternate variant
  localparam logic [6:0] ADDR_ALERT   = 7'h0c;  // smbus alert response

  // register offsets (read and write share one offset)
  localparam logic [7:0] OFS_LOCAL_VAL   = 8'h00;
  localparam logic [7:0] OFS_REMOTE_HI   = 8'h01;
  localparam logic [7:0] OFS_STATUS      = 8'h02;
  localparam logic [7:0] OFS_CONFIG      = 8'h03;
  localparam logic [7:0] OFS_LOCAL_HIGH  = 8'h05;
  localparam logic [7:0] OFS_LOCAL_LOW   = 8'h06;
  localparam logic [7:0] OFS_REMOTE_HIGH = 8'h07;
  localparam logic [7:0] OFS_REMOTE_LOW  = 8'h08;
  localparam logic [7:0] OFS_REMOTE_LO   = 8'h10;
  localparam logic [7:0] OFS_REMOTE_OFS  = 8'h11;
  localparam logic [7:0] OFS_LOCAL_OFS   = 8'h12;
  localparam logic [7:0] OFS_REMOTE_OT   = 8'h19;
  localparam logic [7:0] OFS_LOCAL_OT    = 8'h20;
  localparam logic [7:0] OFS_HYST        = 8'h21;

  // configuration fields
  localparam int CFG_RANGE_BIT  = 2;  // 1 = extended range
  localparam int CFG_SECOND_BIT = 5;  // 1 = alarm pin acts as second ot
  localparam int CFG_MASK_BIT   = 7;  // 1 = alarm masked

  // status fields
  localparam int ST_LOCAL_HIGH  = 6;
  localparam int ST_LOCAL_LOW   = 5;
  localparam int ST_REMOTE_HIGH = 4;
  localparam int ST_REMOTE_LOW  = 3;
  localparam int ST_REMOTE_OT   = 1;
  localparam int ST_LOCAL_OT    = 0;

  // reset values
  localparam logic [7:0] RST_CONFIG    = 8'h00;
  localparam logic [7:0] RST_HIGH      = 8'h55;
  localparam logic [7:0] RST_LOW       = 8'h00;
  localparam logic [7:0] RST_LOCAL_OT  = 8'h55;
  localparam logic [7:0] RST_REMOTE_OT = 8'h6c;  // 108 degrees
  localparam logic [7:0] RST_HYST      = 8'h0a;
  localparam logic [7:0] RST_OFS       = 8'h00;

  // encoding, quarter-degree units
  localparam logic signed [11:0] EXT_OFFSET_Q = 12'sh100;  // +64 degrees
  localparam logic [9:0]         MAX_DEF_Q    = 10'h1ff;   // 127.75
  localparam logic [9:0]         MAX_EXT_Q    = 10'h3ff;   // 191.75

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS  = 20000;  // one conversion slot
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;

  // register write carried from the serial port
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
  } tm_wr_t;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_AACK = 3'b010,
    BUS_WBYT = 3'b011,
    BUS_WACK = 3'b100,
    BUS_RBYT = 3'b101,
    BUS_RACK = 3'b110
  } tm_bus_st_t;
endpackage

// File: hdl/tm_serial_target.sv
`timescale 1ns/1ps
module tm_serial_target (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_oe,
  // device side
  input  wire logic [6:0]         own_addr,
  input  wire logic               alert_pending,
  input  wire logic [7:0]         rd_data,
  output logic [7:0]              ptr,
  output tm_pkg::tm_wr_t          wr,
  output logic                    wr_valid,
  output logic                    rd_strobe,
  output logic                    ara_ack
);
  import tm_pkg::*;

  logic [2:0]  scl_s, sda_s;           // three-flop synchronisers
  logic        scl_reg, scl_next;      // filtered levels
  logic        sda_reg, sda_next;
  tm_bus_st_t  st_reg, st_next;        // byte-level state
  logic [3:0]  cnt_reg, cnt_next;      // bit count
  logic [7:0]  sh_reg, sh_next;        // shift register
  logic [7:0]  ptr_reg, ptr_next;      // address pointer
  logic        first_reg, first_next;  // next write byte is pointer
  logic        second_reg, second_next;
  logic        ara_reg, ara_next;      // alert response in progress
  logic        rw_reg, rw_next;        // read direction
  logic        oe_reg, oe_next;
  logic        wv_next, rs_next, aa_next;
  tm_wr_t      wr_reg, wr_next;
  logic        rise, fall, start, stop;

  // level changes count once second and third flops agree
  assign scl_next = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_reg;
  assign sda_next = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_reg;
  assign rise  = scl_next & ~scl_reg;
  assign fall  = ~scl_next & scl_reg;
  assign start = scl_reg & scl_next & sda_reg & ~sda_next;
  assign stop  = scl_reg & scl_next & ~sda_reg & sda_next;

  // protocol next state
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    second_next = second_reg;
    ara_next = ara_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    wr_next = wr_reg;
    wv_next = 1'b0;
    rs_next = 1'b0;
    aa_next = 1'b0;
    if (start) begin
      st_next = BUS_ADDR;  // repeated start also lands here
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop) begin
      st_next = BUS_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        BUS_IDLE: begin
          oe_next = 1'b0;
        end
        BUS_ADDR: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            // own address, or alert response while alerting
            rw_next = sh_reg[0];
            ara_next = (sh_reg[7:1] == ADDR_ALERT);
            if (sh_reg[7:1] == own_addr) begin
              st_next = BUS_AACK;
              oe_next = 1'b1;
            end else if (ara_next && sh_reg[0] && alert_pending) begin
              st_next = BUS_AACK;
              oe_next = 1'b1;
            end else begin
              st_next = BUS_IDLE;
            end
          end
        end
        BUS_AACK: begin
          if (fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              // load byte and drive its msb
              sh_next = ara_reg ? {own_addr, 1'b0} : rd_data;
              rs_next = ~ara_reg;
              oe_next = ~sh_next[7];
              st_next = BUS_RBYT;
            end else begin
              oe_next = 1'b0;
              first_next = 1'b1;
              second_next = 1'b0;
              st_next = BUS_WBYT;
            end
          end
        end
        BUS_WBYT: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == 4'h8) begin
            if (first_reg) begin
              ptr_next = sh_reg;
              first_next = 1'b0;
              second_next = 1'b1;
              oe_next = 1'b1;
              st_next = BUS_WACK;
            end else if (second_reg) begin
              wr_next.ptr = ptr_reg;
              wr_next.data = sh_reg;
              wv_next = 1'b1;
              second_next = 1'b0;
              oe_next = 1'b1;
              st_next = BUS_WACK;
            end else begin
              st_next = BUS_IDLE;  // third byte refused
            end
          end
        end
        BUS_WACK: begin
          if (fall) begin
            oe_next = 1'b0;
            cnt_next = 4'h0;
            st_next = BUS_WBYT;
          end
        end
        BUS_RBYT: begin
          if (rise) begin
            cnt_next = cnt_reg + 4'h1;
          end else if (fall) begin
            if (cnt_reg == 4'h8) begin
              oe_next = 1'b0;
              aa_next = ara_reg;
              st_next = BUS_RACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_next[7];
            end
          end
        end
        BUS_RACK: begin
          if (rise) begin
            st_next = BUS_IDLE;  // one byte per read
          end
        end
        default: begin
          st_next = BUS_IDLE;
        end
      endcase
    end
  end

  // registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      st_reg <= BUS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      second_reg <= 1'b0;
      ara_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_reg <= '0;
      wr_valid <= 1'b0;
      rd_strobe <= 1'b0;
      ara_ack <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      scl_reg <= scl_next;
      sda_reg <= sda_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      second_reg <= second_next;
      ara_reg <= ara_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
      wr_reg <= wr_next;
      wr_valid <= wv_next;
      rd_strobe <= rs_next;
      ara_ack <= aa_next;
    end
  end

  assign sda_oe = oe_reg;
  assign ptr    = ptr_reg;
  assign wr     = wr_reg;
endmodule

// File: hdl/tm_temp_monitor.sv
`timescale 1ns/1ps
// How it works
// - answers at 0x4C, or 0x4D variant
// - alarm low when either channel out of range
// - overtemp output is a comparator level
// - alarm pin can act as second overtemp
// - converter free-runs without host request
// - conversions alternate local and remote
// - result stored in measured channel's register
// - each result checked against high, low, overtemp
// - local result at 0x00, one degree
// - remote integer at 0x01, fraction at 0x10
// - remote low byte uses two msbs only
// - default 0..127, extended -64..191 range
// - remote overtemp limit resets to 108
// - answers smbus alert response while alerting
// - offset registers calibrate the results
// - low byte read locks high byte
// - config bit 2 selects extended range
// - extended range adds 64, offset binary
// - alarm when above high or at/below low
module tm_temp_monitor #(
  parameter logic            ALT_ADDR  = 1'b0,
  parameter int unsigned     CONV_CYC  = tm_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst_n,
  // serial pins
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe,
  // alarm pins, active low
  output logic                    alert_n,
  output logic                    overtemp_comparator_out_n,
  // converter front end
  input  wire logic signed [7:0]  local_sample,
  input  wire logic signed [9:0]  remote_sample,
  output logic                    sel_remote
);
  import tm_pkg::*;

  logic [6:0]  own_addr;           // bus address of this variant
  logic [7:0]  ptr;                // address pointer from serial port
  tm_wr_t      wr;                 // write request
  logic        wr_valid;           // write pulse
  logic        rd_strobe;          // read of ptr started
  logic        ara_ack;            // alert response sent
  logic [7:0]  rd_data;            // read mux
  logic        alert_pending;      // alert may answer response
  logic        sda_oe_w;

  // converter state
  logic [31:0] cyc_reg, cyc_next;      // slot counter
  logic        sel_reg, sel_next;      // 1 = remote channel
  logic [7:0]  loc_reg, loc_next;      // local value
  logic [9:0]  rem_reg, rem_next;      // remote value, internal
  logic [7:0]  rhi_reg, rhi_next;      // remote high byte, as read
  logic [1:0]  rlo_reg, rlo_next;      // remote fraction, as read
  logic        lock_reg, lock_next;    // high byte held

  // host registers
  logic [7:0]  cfg_reg, cfg_next;
  logic [7:0]  lhi_reg, lhi_next;      // local high limit
  logic [7:0]  llo_reg, llo_next;      // local low limit
  logic [7:0]  rhl_reg, rhl_next;      // remote high limit
  logic [7:0]  rll_reg, rll_next;      // remote low limit
  logic [7:0]  lot_reg, lot_next;      // local overtemp limit
  logic [7:0]  rot_reg, rot_next;      // remote overtemp limit
  logic [7:0]  hys_reg, hys_next;      // overtemp hysteresis
  logic [7:0]  lof_reg, lof_next;      // local offset, degrees
  logic [7:0]  rof_reg, rof_next;      // remote offset, degrees

  // alarm state
  logic [7:0]  st_reg, st_next;        // status flags
  logic        alr_reg, alr_next;      // latched alarm
  logic        ot_reg, ot_next;        // overtemp comparator state
  logic        ot2_reg, ot2_next;      // second overtemp state
  logic        alert_n_reg, alert_n_next;
  logic        ot_n_reg, ot_n_next;

  logic        ext;                    // extended range active
  logic        conv_end;               // slot finished
  logic [9:0]  loc_q, rem_q;           // encoded new results
  logic        any_limit;

  assign own_addr = ALT_ADDR ? ADDR_ALT : ADDR_DEFAULT;
  assign ext = cfg_reg[CFG_RANGE_BIT];

  // add offset and range shift, clamp, quarter-degree result
  function automatic logic [9:0] tm_encode(input logic signed [11:0] q,
                                           input logic signed [7:0] ofs,
                                           input logic e);
    logic signed [11:0] s;
    logic [9:0]         top;
    s = q + {{2{ofs[7]}}, ofs, 2'b00};
    s = e ? s + EXT_OFFSET_Q : s;
    top = e ? MAX_EXT_Q : MAX_DEF_Q;
    if (s < 12'sd0) begin
      tm_encode = 10'h000;
    end else if (s > $signed({2'b00, top})) begin
      tm_encode = top;
    end else begin
      tm_encode = s[9:0];
    end
  endfunction

  assign loc_q = tm_encode({{2{local_sample[7]}}, local_sample, 2'b00},
                           lof_reg, ext);
  assign rem_q = tm_encode({{2{remote_sample[9]}}, remote_sample},
                           rof_reg, ext);
  assign conv_end = (cyc_reg == CONV_CYC - 1);

  // converter: free-running slots, alternating channels
  always_comb begin
    cyc_next = conv_end ? 32'h0 : cyc_reg + 32'h1;
    sel_next = conv_end ? ~sel_reg : sel_reg;
    loc_next = loc_reg;
    rem_next = rem_reg;
    rhi_next = rhi_reg;
    rlo_next = rlo_reg;
    lock_next = lock_reg;
    if (conv_end && !sel_reg) begin
      loc_next = loc_q[9:2];
    end
    if (conv_end && sel_reg) begin
      rem_next = rem_q;
      rlo_next = rem_q[1:0];
      if (!lock_reg) begin
        rhi_next = rem_q[9:2];
      end
    end
    // low byte read locks, high byte read frees
    if (rd_strobe && ptr == OFS_REMOTE_LO) begin
      lock_next = 1'b1;
    end else if (rd_strobe && ptr == OFS_REMOTE_HI) begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 32'h0;
      sel_reg <= 1'b0;
      loc_reg <= 8'h00;
      rem_reg <= 10'h000;
      rhi_reg <= 8'h00;
      rlo_reg <= 2'b00;
      lock_reg <= 1'b0;
    end else begin
      cyc_reg <= cyc_next;
      sel_reg <= sel_next;
      loc_reg <= loc_next;
      rem_reg <= rem_next;
      rhi_reg <= rhi_next;
      rlo_reg <= rlo_next;
      lock_reg <= lock_next;
    end
  end

  // host register writes; value and status offsets fall through
  always_comb begin
    cfg_next = cfg_reg;
    lhi_next = lhi_reg;
    llo_next = llo_reg;
    rhl_next = rhl_reg;
    rll_next = rll_reg;
    lot_next = lot_reg;
    rot_next = rot_reg;
    hys_next = hys_reg;
    lof_next = lof_reg;
    rof_next = rof_reg;
    if (wr_valid) begin
      case (wr.ptr)
        OFS_CONFIG:      cfg_next = wr.data;
        OFS_LOCAL_HIGH:  lhi_next = wr.data;
        OFS_LOCAL_LOW:   llo_next = wr.data;
        OFS_REMOTE_HIGH: rhl_next = wr.data;
        OFS_REMOTE_LOW:  rll_next = wr.data;
        OFS_LOCAL_OT:    lot_next = wr.data;
        OFS_REMOTE_OT:   rot_next = wr.data;
        OFS_HYST:        hys_next = wr.data;
        OFS_LOCAL_OFS:   lof_next = wr.data;
        OFS_REMOTE_OFS:  rof_next = wr.data;
        default:         cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= RST_CONFIG;
      lhi_reg <= RST_HIGH;
      llo_reg <= RST_LOW;
      rhl_reg <= RST_HIGH;
      rll_reg <= RST_LOW;
      lot_reg <= RST_LOCAL_OT;
      rot_reg <= RST_REMOTE_OT;
      hys_reg <= RST_HYST;
      lof_reg <= RST_OFS;
      rof_reg <= RST_OFS;
    end else begin
      cfg_reg <= cfg_next;
      lhi_reg <= lhi_next;
      llo_reg <= llo_next;
      rhl_reg <= rhl_next;
      rll_reg <= rll_next;
      lot_reg <= lot_next;
      rot_reg <= rot_next;
      hys_reg <= hys_next;
      lof_reg <= lof_next;
      rof_reg <= rof_next;
    end
  end

  // limit checks and pin levels
  always_comb begin
    logic [8:0] lsum, rsum;
    lsum = {1'b0, loc_reg} + {1'b0, hys_reg};
    rsum = {1'b0, rem_reg[9:2]} + {1'b0, hys_reg};
    st_next = 8'h00;
    st_next[ST_LOCAL_HIGH]  = loc_reg > lhi_reg;
    st_next[ST_LOCAL_LOW]   = loc_reg <= llo_reg;
    st_next[ST_REMOTE_HIGH] = rem_reg[9:2] > rhl_reg;
    st_next[ST_REMOTE_LOW]  = rem_reg[9:2] <= rll_reg;
    st_next[ST_LOCAL_OT]    = loc_reg > lot_reg;
    st_next[ST_REMOTE_OT]   = rem_reg[9:2] > rot_reg;
    any_limit = st_reg[ST_LOCAL_HIGH] | st_reg[ST_LOCAL_LOW] |
                st_reg[ST_REMOTE_HIGH] | st_reg[ST_REMOTE_LOW];
    // latch holds until alert response; a new violation wins
    alr_next = any_limit | (alr_reg & ~ara_ack);
    // overtemp asserts above limit, frees at limit minus hysteresis
    if (st_reg[ST_LOCAL_OT] | st_reg[ST_REMOTE_OT]) begin
      ot_next = 1'b1;
    end else if (lsum <= {1'b0, lot_reg} && rsum <= {1'b0, rot_reg}) begin
      ot_next = 1'b0;
    end else begin
      ot_next = ot_reg;
    end
    // second output follows high limits only
    if (st_reg[ST_LOCAL_HIGH] | st_reg[ST_REMOTE_HIGH]) begin
      ot2_next = 1'b1;
    end else if (lsum <= {1'b0, lhi_reg} && rsum <= {1'b0, rhl_reg}) begin
      ot2_next = 1'b0;
    end else begin
      ot2_next = ot2_reg;
    end
    if (cfg_reg[CFG_SECOND_BIT]) begin
      alert_n_next = ~ot2_reg;
    end else begin
      alert_n_next = ~(alr_reg & ~cfg_reg[CFG_MASK_BIT]);
    end
    ot_n_next = ~ot_reg;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= 8'h00;
      alr_reg <= 1'b0;
      ot_reg <= 1'b0;
      ot2_reg <= 1'b0;
      alert_n_reg <= 1'b1;
      ot_n_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      alr_reg <= alr_next;
      ot_reg <= ot_next;
      ot2_reg <= ot2_next;
      alert_n_reg <= alert_n_next;
      ot_n_reg <= ot_n_next;
    end
  end

  assign alert_pending = alr_reg & ~cfg_reg[CFG_MASK_BIT] &
                         ~cfg_reg[CFG_SECOND_BIT];

  // register read mux
  always_comb begin
    case (ptr)
      OFS_LOCAL_VAL:   rd_data = loc_reg;
      OFS_REMOTE_HI:   rd_data = rhi_reg;
      OFS_REMOTE_LO:   rd_data = {rlo_reg, 6'h00};
      OFS_STATUS:      rd_data = st_reg;
      OFS_CONFIG:      rd_data = cfg_reg;
      OFS_LOCAL_HIGH:  rd_data = lhi_reg;
      OFS_LOCAL_LOW:   rd_data = llo_reg;
      OFS_REMOTE_HIGH: rd_data = rhl_reg;
      OFS_REMOTE_LOW:  rd_data = rll_reg;
      OFS_LOCAL_OT:    rd_data = lot_reg;
      OFS_REMOTE_OT:   rd_data = rot_reg;
      OFS_HYST:        rd_data = hys_reg;
      OFS_LOCAL_OFS:   rd_data = lof_reg;
      OFS_REMOTE_OFS:  rd_data = rof_reg;
      default:         rd_data = 8'h00;
    endcase
  end

  // serial port
  tm_serial_target u_port (
    .clock         (clock),
    .rst_n         (rst_n),
    .scl_in        (scl_in),
    .sda_in        (sda_in),
    .sda_oe        (sda_oe_w),
    .own_addr      (own_addr),
    .alert_pending (alert_pending),
    .rd_data       (rd_data),
    .ptr           (ptr),
    .wr            (wr),
    .wr_valid      (wr_valid),
    .rd_strobe     (rd_strobe),
    .ara_ack       (ara_ack)
  );

  assign sda_out = 1'b0;  // open drain, only pulls low
  assign sda_oe = sda_oe_w;
  assign sel_remote = sel_reg;
  assign alert_n = alert_n_reg;
  assign overtemp_comparator_out_n = ot_n_reg;
endmodule

// File: verif/tm_props.sv
`timescale 1ns/1ps
module tm_props #(
  parameter int unsigned CONV_CYC = 20
) (
  // clock and reset
  input wire logic              clock,
  input wire logic              rst_n,
  // watched pins
  input wire logic              scl_in,
  input wire logic              sda_in,
  input wire logic              sda_out,
  input wire logic              sda_oe,
  input wire logic              alert_n,
  input wire logic              overtemp_comparator_out_n,
  input wire logic signed [7:0] local_sample,
  input wire logic signed [9:0] remote_sample,
  input wire logic              sel_remote
);
  int unsigned slot_cnt;  // clocks since the channel last changed
  logic        sel_q;     // channel at the previous edge
  logic        flip;      // channel changes at this edge
  assign flip = sel_remote != sel_q;
  // counts the length of each conversion slot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= 0;
      sel_q    <= 1'b0;
    end else begin
      slot_cnt <= flip ? 0 : slot_cnt + 1;
      sel_q    <= sel_remote;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_drain_only: assert property (sda_out == 1'b0)
    else $error("sda_out not low");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda_oe moved with scl high");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("pull on sda too short");
  a_release_hold: assert property ($fell(sda_oe) |=> !sda_oe [*8])
    else $error("release of sda too short");
  a_reset_idle: assert property ($rose(rst_n) |-> alert_n && !sda_oe)
    else $error("pins not idle after reset");
  a_first_local: assert property ($rose(rst_n) |-> !sel_remote [*8])
    else $error("first slot not local");
  a_slot_early: assert property (flip |-> slot_cnt + 3 >= CONV_CYC)
    else $error("channel changed too early");
  a_slot_late: assert property (slot_cnt <= CONV_CYC + 3)
    else $error("converter stalled");
  cover property ($fell(alert_n));
  cover property ($fell(overtemp_comparator_out_n));
  cover property ($rose(sda_oe));
endmodule
bind tm_temp_monitor tm_props #(.CONV_CYC(CONV_CYC)) u_props (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .alert_n(alert_n),
  .overtemp_comparator_out_n(overtemp_comparator_out_n),
  .local_sample(local_sample), .remote_sample(remote_sample),
  .sel_remote(sel_remote));

// File: verif/tm_host.sv
`timescale 1ns/1ps
module tm_host (
  // bus pins, pulled up outside
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  localparam realtime QTR = 31.25;  // quarter of the 125 ns period
  // bus idles released, clock still
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // one bit: data moves with scl low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #QTR scl = 1'b1;
    #QTR r = sda;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  // start, also used as repeated start
  task automatic start();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask
  // eight bits out, msb first, then the ack slot
  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // eight bits in, then nack to end the read
  task automatic byte_in(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, v[i]);
    end
    bit_io(1'b1, r);
  endtask
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
  import tm_pkg::*;
  localparam int unsigned CONV = 20;  // shortened conversion slot
  logic              clock;
  logic              rst_n;
  logic signed [7:0] local_sample;
  logic signed [9:0] remote_sample;
  logic              scl;
  logic              host_pull;
  logic              sda_oe;
  logic              sda_out;
  logic              alert_n;
  logic              ot_n;
  logic              sel_remote;
  wire logic         sda;          // pulled-up data line
  logic [7:0]        rd;           // last byte read
  logic              ack;          // last ack seen
  int                fail_count  = 0;
  int                checks_done = 0;
  assign sda = !((sda_oe && !sda_out) || host_pull);
  tm_temp_monitor #(.ALT_ADDR(1'b0), .CONV_CYC(CONV)) uut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .alert_n(alert_n),
    .overtemp_comparator_out_n(ot_n), .local_sample(local_sample),
    .remote_sample(remote_sample), .sel_remote(sel_remote));
  tm_host host (.scl(scl), .sda_pull(host_pull), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pin(input string nm, input logic v, e);
    chk(nm, {7'h0, v}, {7'h0, e});
  endtask
  task automatic wr_reg(input logic [7:0] p, d);
    host.start();
    host.byte_out({ADDR_DEFAULT, 1'b0}, ack);
    host.byte_out(p, ack);
    host.byte_out(d, ack);
    host.stop();
    pin("data ack", ack, 1'b1);
  endtask
  // pointer write, repeated start, one byte read
  task automatic rd_reg(input logic [7:0] p, e, input string nm);
    host.start();
    host.byte_out({ADDR_DEFAULT, 1'b0}, ack);
    host.byte_out(p, ack);
    host.start();
    host.byte_out({ADDR_DEFAULT, 1'b1}, ack);
    host.byte_in(rd);
    host.stop();
    chk(nm, rd, e);
  endtask
  task automatic ara();
    host.start();
    host.byte_out({ADDR_ALERT, 1'b1}, ack);
    host.byte_in(rd);
    host.stop();
  endtask
  // new front-end samples, then three slots to settle
  task automatic set_temp(input logic signed [7:0] l,
                          input logic signed [9:0] r);
    @(posedge clock);
    #1 local_sample = l;
    remote_sample = r;
    repeat (3 * CONV) @(posedge clock);
    #1;
  endtask
  task automatic results();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    #300_000;
    chk("run time", 8'h00, 8'h01);
    results();
  end
  initial begin
    rst_n = 1'b0;
    local_sample = 8'sd25;
    remote_sample = 10'sd163;  // 40.75 degrees
    repeat (3) @(posedge clock);
    #1 rst_n = 1'b1;
    pin("ot reset", ot_n, 1'b1);
    host.start();
    host.byte_out({ADDR_ALT, 1'b0}, ack);
    host.stop();
    pin("alt ack", ack, 1'b0);
    set_temp(8'sd25, 10'sd163);
    rd_reg(OFS_LOCAL_VAL, 8'h19, "local");
    rd_reg(OFS_REMOTE_LO, 8'hc0, "rem lo");
    set_temp(8'sd25, 10'sd200);
    rd_reg(OFS_REMOTE_HI, 8'h28, "rem hi lock");
    rd_reg(OFS_REMOTE_HI, 8'h32, "rem hi");
    wr_reg(OFS_LOCAL_VAL, 8'h77);
    rd_reg(OFS_LOCAL_VAL, 8'h19, "local ro");
    rd_reg(OFS_REMOTE_OT, 8'h6c, "rem ot lim");
    wr_reg(OFS_LOCAL_OFS, 8'h03);
    rd_reg(OFS_LOCAL_VAL, 8'h1c, "offset");
    wr_reg(OFS_LOCAL_OFS, 8'h00);
    wr_reg(OFS_CONFIG, 8'h04);
    rd_reg(OFS_LOCAL_VAL, 8'h59, "ext local");
    rd_reg(OFS_REMOTE_HI, 8'h72, "ext remote");
    wr_reg(OFS_CONFIG, 8'h00);
    set_temp(8'sd25, 10'sd200);
    pin("alarm latched", alert_n, 1'b0);
    pin("ot release", ot_n, 1'b1);
    ara();
    chk("ara", rd, {ADDR_DEFAULT, 1'b0});
    set_temp(8'sd100, 10'sd200);
    pin("alarm high", alert_n, 1'b0);
    pin("ot high", ot_n, 1'b0);
    set_temp(8'sd25, 10'sd200);
    pin("ot cool", ot_n, 1'b1);
    ara();
    set_temp(8'sd25, 10'sd200);
    pin("alarm clear", alert_n, 1'b1);
    ara();
    pin("ara idle", ack, 1'b0);
    set_temp(-8'sd5, 10'sd200);
    pin("alarm low", alert_n, 1'b0);
    rd_reg(OFS_LOCAL_VAL, 8'h00, "clamp");
    set_temp(8'sd25, 10'sd200);
    ara();
    wr_reg(OFS_CONFIG, 8'h20);
    set_temp(8'sd100, 10'sd200);
    pin("second ot on", alert_n, 1'b0);
    set_temp(8'sd25, 10'sd200);
    pin("second ot off", alert_n, 1'b1);
    wr_reg(OFS_CONFIG, 8'h80);
    set_temp(8'sd100, 10'sd200);
    pin("alarm masked", alert_n, 1'b1);
    pin("ot unmasked", ot_n, 1'b0);
    rd_reg(OFS_STATUS, 8'h41, "status");
    results();
  end
endmodule
